// File: hw/pkt_mem.sv
`timescale 1ns/1ps
module pkt_mem (
  input  wire logic                         pclk,
  input  wire logic                         presetn,
  input  wire logic                         we,
  input  wire logic [txbuf_pkg::ADDR_W-1:0] waddr,
  input  wire logic [txbuf_pkg::WORD_W-1:0] wdata,
  input  wire logic [txbuf_pkg::ADDR_W-1:0] raddr,
  output logic      [txbuf_pkg::WORD_W-1:0] rdata
);
  logic [txbuf_pkg::WORD_W-1:0] mem [2**txbuf_pkg::ADDR_W];

  always_ff @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata <= '0;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule // pkt_mem

// File: hw/sync3.sv
`timescale 1ns/1ps
module sync3 #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;
  wire  [W-1:0] agree = ~(s2_ff ^ s3_ff);

  // a change counts only once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q     <= '0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      q     <= (agree & s3_ff) | (~agree & q);
    end
  end
endmodule // sync3

// File: hw/tx_packet_buffer_ordering.sv
`timescale 1ns/1ps
module tx_packet_buffer_ordering #(
  parameter logic [7:0] response_accept_window = 8'h01
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic [7:0]           paddr,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic [1:0]           write_enable_in,
  input  wire logic                 response_buf_write_enable,
  input  wire logic [2:0][63:0]     wr_data,
  input  wire logic [2:0]           wr_sop,
  input  wire logic [2:0]           wr_eop,
  input  wire logic [2:0][2:0]      wr_mty,
  output logic      [2:0]           buf_available,
  output logic      [2:0]           write_reject,
  output logic                      tx_valid,
  input  wire logic                 tx_ready,
  output logic      [63:0]          tx_data,
  output logic                      tx_sop,
  output logic                      tx_eop,
  output logic      [2:0]           tx_mty,
  output logic      [1:0]           tx_class,
  input  wire logic                 rx_pll_lock,
  input  wire logic                 rx_pll_async_reset,
  input  wire logic                 tx_pll_async_reset,
  input  wire logic                 reference_clock_in,
  input  wire logic                 warm_reset_req,
  input  wire logic                 cold_reset_req,
  output logic                      rx_quarter_rate_clock,
  output logic                      rx_quarter_clock_locked,
  output logic                      reference_clock_in_warm_reset_out,
  output logic                      reference_clock_in_cold_reset_out,
  output logic                      rx_pll_reset_out,
  output logic                      tx_pll_reset_out
);
  localparam int W = txbuf_pkg::WORD_W;
  localparam int RP = txbuf_pkg::CLS_RESP;

  function automatic logic room_ok(logic [5:0] base, logic res,
                                   logic [5:0] rp);
    logic [6:0] used;
    used = {1'b0, 6'(base - rp)} + (res ? txbuf_pkg::PKT_WORDS : 7'h00);
    return used <= (txbuf_pkg::DEPTH_WORDS - txbuf_pkg::PKT_WORDS);
  endfunction

  function automatic logic posted_done(logic [7:0] bar, logic [7:0] sent);
    logic [7:0] d;
    d = bar - sent;
    return $signed(d) <= 0;
  endfunction

  function automatic logic [2:0] pick(logic [2:0] rdy, logic [1:0] last);
    logic       f;
    logic [1:0] idx;
    int         cand;
    f = 1'b0;
    idx = 2'h0;
    for (int k = 1; k <= 3; k++) begin
      cand = (int'(last) + k) % 3;
      if (rdy[cand] && !f) begin
        f = 1'b1;
        idx = 2'(cand);
      end
    end
    return {f, idx};
  endfunction

  txbuf_pkg::sched_st_t st_ff;
  txbuf_pkg::inj_st_t   inj_st_ff;
  logic [1:0]  sel_ff;
  logic [1:0]  rr_ff;
  logic [2:0]  blocked_ff;
  logic [7:0]  post_started_ff;
  logic [7:0]  post_sent_ff;
  logic        tx_hold_ff;
  logic [7:0]  tx_bar_ff;
  logic [7:0]  win_cnt_ff;
  logic        inj_pend_ff;
  logic [31:0] inj_data_ff;
  logic [1:0]  mode_ff;
  logic        qdiv_ff;
  logic        ref_q_ff;

  logic [2:0] wr_en_all;
  logic [2:0] adv;
  logic [2:0] room_w;
  logic [2:0] nxt_room;
  logic [2:0] has_w;
  logic [2:0] acc_start_w;
  logic [2:0] reject_w;
  logic [2:0] over_w;
  logic [2:0] in_pkt_w;
  logic [W-1:0] rdata_w [3];
  logic [W-1:0] head;
  logic [2:0] pk;
  logic       win_ok;
  logic       sent_post;
  logic       fetch_blk;
  logic       inj_go;
  logic [5:0] sy;

  assign wr_en_all = {response_buf_write_enable, write_enable_in};
  assign win_ok    = win_cnt_ff <= response_accept_window;
  assign adv = {3{st_ff == txbuf_pkg::S_SEND && tx_ready}}
               & (3'h1 << sel_ff);

  localparam int CLS_POST_I = txbuf_pkg::CLS_POST;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  for (genvar c = 0; c < txbuf_pkg::NCLS; c++) begin : g_cls
    logic [5:0] wptr_ff, cptr_ff, sptr_ff, rptr_ff;
    logic [5:0] nxt_wptr, nxt_cptr, nxt_sptr, nxt_rptr;
    logic       in_pkt_ff, drop_ff, room_ff;
    logic [3:0] len_ff;
    logic       en, try, can, acc_start, acc_mid, over, bad, acc, iwe;
    logic       nxt_in, hold;
    logic [W-1:0] wword;

    assign en  = wr_en_all[c];
    assign try = en && !in_pkt_ff && !drop_ff;
    assign can = (c == RP)
      ? (buf_available[c] || (inj_st_ff == txbuf_pkg::I_BLOCK && win_ok
         && room_ff))
      : buf_available[c];
    assign acc_start = try && wr_sop[c] && can;
    assign bad       = try && !(wr_sop[c] && can);
    assign over = en && in_pkt_ff && len_ff == txbuf_pkg::LEN_MAX;
    assign acc_mid   = en && in_pkt_ff && !over;
    assign acc       = acc_start || acc_mid;
    assign iwe       = (c == RP) && inj_st_ff == txbuf_pkg::I_WRITE;
    // cleared pass bit on a non-posted or response start
    assign hold = (c != txbuf_pkg::CLS_POST) &&
      !(iwe ? inj_data_ff[txbuf_pkg::PPW_BIT]
            : wr_data[c][txbuf_pkg::PPW_BIT]);
    // barrier taken from the registered count: same-cycle posted
    // starts are not counted as earlier
    assign wword = iwe
      ? {post_started_ff, hold, 2'b11, txbuf_pkg::MTY_ODD,
         32'h0000_0000, inj_data_ff}
      : {post_started_ff, hold && acc_start, acc_start, wr_eop[c],
         wr_mty[c], wr_data[c]};
    assign nxt_wptr = over ? cptr_ff
                    : (acc || iwe) ? wptr_ff + 6'h01 : wptr_ff;
    // commit only at the end word; reader never sees more
    assign nxt_cptr = ((acc && wr_eop[c]) || iwe)
                    ? wptr_ff + 6'h01 : cptr_ff;
    assign nxt_sptr = acc_start ? wptr_ff : sptr_ff;
    assign nxt_in   = acc ? !wr_eop[c] : (in_pkt_ff && !over);
    assign nxt_rptr = rptr_ff + {5'h00, adv[c]};
    assign nxt_room[c] = room_ok(nxt_in ? nxt_sptr : nxt_cptr, nxt_in,
                                 nxt_rptr);
    assign room_w[c]      = room_ff;
    assign has_w[c]       = rptr_ff != cptr_ff;
    assign acc_start_w[c] = acc_start;
    assign reject_w[c]    = bad || over;
    assign over_w[c]      = over;
    assign in_pkt_w[c]    = in_pkt_ff;

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        wptr_ff   <= 6'h00;
        cptr_ff   <= 6'h00;
        sptr_ff   <= 6'h00;
        rptr_ff   <= 6'h00;
        in_pkt_ff <= 1'b0;
        drop_ff   <= 1'b0;
        room_ff   <= 1'b1;
        len_ff    <= 4'h0;
      end else begin
        wptr_ff   <= nxt_wptr;
        cptr_ff   <= nxt_cptr;
        sptr_ff   <= nxt_sptr;
        rptr_ff   <= nxt_rptr;
        in_pkt_ff <= nxt_in;
        room_ff   <= nxt_room[c];
        // swallow the tail of a refused packet up to its end word
        drop_ff   <= (bad || over) ? !wr_eop[c]
                   : (drop_ff && !(en && wr_eop[c]));
        len_ff    <= acc_start ? txbuf_pkg::LEN_ONE
                   : acc_mid ? len_ff + 4'h1 : len_ff;
      end
    end

    pkt_mem u_mem (
      .pclk    (pclk),
      .presetn (presetn),
      .we      (acc || iwe),
      .waddr   (wptr_ff[txbuf_pkg::ADDR_W-1:0]),
      .wdata   (wword),
      .raddr   (nxt_rptr[txbuf_pkg::ADDR_W-1:0]),
      .rdata   (rdata_w[c])
    );

    AST_NO_SOP: assert property (try && !wr_sop[c] |=> write_reject[c])
      else $error("start word without sop not rejected");
    AST_REJ_NOAVAIL: assert property (
      try && wr_sop[c] && !buf_available[c] && (c != RP) |=>
      write_reject[c] && $stable(cptr_ff))
      else $error("start while unavailable not rejected");
    AST_OVERLONG: assert property (over |=> wptr_ff == cptr_ff
      && !in_pkt_ff)
      else $error("overlong packet did not revert");
  end

  // availability: room for a packet; response also closed while the
  // device uses the buffer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_available <= 3'h7;
      write_reject  <= 3'h0;
    end else begin
      buf_available <= nxt_room & {inj_go ? 1'b0
                       : inj_st_ff == txbuf_pkg::I_IDLE, 2'b11};
      write_reject  <= reject_w;
    end
  end

  // posted starts, backed out when a started posted packet is refused
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      post_started_ff <= 8'h00;
    end else begin
      post_started_ff <= post_started_ff
        + {7'h00, acc_start_w[txbuf_pkg::CLS_POST]}
        - {7'h00, over_w[txbuf_pkg::CLS_POST]};
    end
  end

  // device-generated responses into the response buffer
  assign inj_go = inj_st_ff == txbuf_pkg::I_IDLE && inj_pend_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inj_st_ff  <= txbuf_pkg::I_IDLE;
      win_cnt_ff <= 8'h00;
    end else begin
      unique case (inj_st_ff)
        txbuf_pkg::I_IDLE: begin
          if (inj_pend_ff) begin
            inj_st_ff  <= txbuf_pkg::I_BLOCK;
            win_cnt_ff <= 8'h01;
          end
        end
        txbuf_pkg::I_BLOCK: begin
          if (win_ok) begin
            win_cnt_ff <= win_cnt_ff + 8'h01;
          end else if (!in_pkt_w[RP] && room_w[RP]) begin
            inj_st_ff <= txbuf_pkg::I_WRITE;
          end
        end
        txbuf_pkg::I_WRITE: inj_st_ff <= txbuf_pkg::I_IDLE;
      endcase
    end
  end

  // link scheduler: round robin between classes, in order within one
  assign pk        = pick(has_w & ~blocked_ff, rr_ff);
  assign head      = rdata_w[sel_ff];
  assign fetch_blk = head[txbuf_pkg::F_SOP] && head[txbuf_pkg::F_HOLD]
    && !posted_done(head[txbuf_pkg::F_BAR +: txbuf_pkg::BAR_W],
                    post_sent_ff);
  assign sent_post = adv[txbuf_pkg::CLS_POST] && tx_eop;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff        <= txbuf_pkg::S_IDLE;
      sel_ff       <= 2'h0;
      rr_ff        <= 2'h2;
      blocked_ff   <= 3'h0;
      post_sent_ff <= 8'h00;
      tx_valid     <= 1'b0;
      tx_data      <= 64'h0000_0000_0000_0000;
      tx_sop       <= 1'b0;
      tx_eop       <= 1'b0;
      tx_mty       <= 3'h0;
      tx_class     <= 2'h0;
      tx_hold_ff   <= 1'b0;
      tx_bar_ff    <= 8'h00;
    end else begin
      if (sent_post) begin
        post_sent_ff <= post_sent_ff + 8'h01;
        blocked_ff   <= 3'h0;
      end
      unique case (st_ff)
        txbuf_pkg::S_IDLE: begin
          if (pk[2]) begin
            sel_ff <= pk[1:0];
            st_ff  <= txbuf_pkg::S_FETCH;
          end
        end
        txbuf_pkg::S_FETCH: begin
          if (fetch_blk) begin
            blocked_ff[sel_ff] <= 1'b1;
            rr_ff <= sel_ff;
            st_ff <= txbuf_pkg::S_IDLE;
          end else begin
            tx_valid   <= 1'b1;
            tx_data    <= head[63:0];
            tx_sop     <= head[txbuf_pkg::F_SOP];
            tx_eop     <= head[txbuf_pkg::F_EOP];
            tx_mty     <= head[txbuf_pkg::F_MTY +: 3];
            tx_class   <= sel_ff;
            tx_hold_ff <= head[txbuf_pkg::F_HOLD];
            tx_bar_ff  <= head[txbuf_pkg::F_BAR +: txbuf_pkg::BAR_W];
            st_ff      <= txbuf_pkg::S_SEND;
          end
        end
        txbuf_pkg::S_SEND: begin
          if (tx_ready) begin
            tx_valid <= 1'b0;
            if (tx_eop) begin
              rr_ff <= sel_ff;
              st_ff <= txbuf_pkg::S_IDLE;
            end else begin
              st_ff <= txbuf_pkg::S_FETCH;
            end
          end
        end
      endcase
    end
  end

  // register slave, one wait state on every access
  logic acc_ph, done, hit_ctrl, hit_inj, hit_stat, wr_err;
  logic [31:0] rd_mux;
  assign acc_ph   = psel && penable && !pready;
  assign done     = psel && penable && pready;
  assign hit_ctrl = paddr == txbuf_pkg::A_CTRL;
  assign hit_inj  = paddr == txbuf_pkg::A_INJ;
  assign hit_stat = paddr == txbuf_pkg::A_STAT;
  assign wr_err   = pwrite ? (hit_inj && inj_pend_ff) || hit_stat
                           || !(hit_ctrl || hit_inj)
                           : !(hit_ctrl || hit_inj || hit_stat);
  assign rd_mux = hit_ctrl ? {30'h0000_0000, mode_ff}
                : hit_inj  ? inj_data_ff
                : hit_stat ? {6'h00, post_sent_ff, post_started_ff,
                              mode_ff, inj_pend_ff,
                              rx_quarter_clock_locked, in_pkt_w,
                              buf_available}
                : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready      <= 1'b0;
      pslverr     <= 1'b0;
      prdata      <= 32'h0000_0000;
      mode_ff     <= txbuf_pkg::MODE_SEP;
      inj_pend_ff <= 1'b0;
      inj_data_ff <= 32'h0000_0000;
    end else begin
      pready  <= acc_ph;
      pslverr <= acc_ph && wr_err;
      prdata  <= (acc_ph && !pwrite) ? rd_mux : 32'h0000_0000;
      if (done && pwrite && hit_ctrl) begin
        mode_ff <= pwdata[1:0];
      end
      if (done && pwrite && hit_inj && !inj_pend_ff) begin
        inj_pend_ff <= 1'b1;
        inj_data_ff <= pwdata;
      end else if (inj_st_ff == txbuf_pkg::I_WRITE) begin
        inj_pend_ff <= 1'b0;
      end
    end
  end

  // system signals: the pll clock is modelled by pclk
  sync3 #(.W(6)) u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({reference_clock_in, cold_reset_req, warm_reset_req,
               tx_pll_async_reset, rx_pll_async_reset, rx_pll_lock}),
    .q       (sy)
  );
  logic rst_tick;
  assign rst_tick = (mode_ff == txbuf_pkg::MODE_RX_TX_REF)
                  ? (qdiv_ff && !rx_quarter_rate_clock)
                  : (sy[5] && !ref_q_ff);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qdiv_ff                 <= 1'b0;
      rx_quarter_rate_clock   <= 1'b0;
      rx_quarter_clock_locked <= 1'b0;
      ref_q_ff                <= 1'b0;
      reference_clock_in_warm_reset_out   <= 1'b1;
      reference_clock_in_cold_reset_out   <= 1'b1;
      rx_pll_reset_out        <= 1'b0;
      tx_pll_reset_out        <= 1'b0;
    end else begin
      qdiv_ff <= !qdiv_ff;
      if (qdiv_ff) begin
        rx_quarter_rate_clock <= !rx_quarter_rate_clock;
      end
      rx_quarter_clock_locked <= sy[0] && !sy[1];
      ref_q_ff <= sy[5];
      if (rst_tick) begin
        reference_clock_in_warm_reset_out <= sy[3];
        reference_clock_in_cold_reset_out <= sy[4];
      end
      rx_pll_reset_out <= sy[1];
      tx_pll_reset_out <= sy[2] && mode_ff == txbuf_pkg::MODE_REF_TX;
    end
  end

  AST_HOLD_ORDER: assert property (tx_valid && tx_sop && tx_hold_ff |->
    posted_done(tx_bar_ff, post_sent_ff))
    else $error("cleared pass packet ahead of posted");
  AST_WIN_REJ: assert property (inj_st_ff == txbuf_pkg::I_BLOCK && !win_ok
    && response_buf_write_enable && wr_sop[RP] && !in_pkt_w[RP]
    && !buf_available[RP] |=> write_reject[RP])
    else $error("late response start accepted");
  AST_WIN_ACC: assert property (acc_start_w[RP] |=> !write_reject[RP])
    else $error("windowed response start rejected");
  AST_INJ_AVAIL: assert property (inj_st_ff == txbuf_pkg::I_WRITE |->
    !buf_available[RP] && $past(!buf_available[RP], 2))
    else $error("response availability high while used");
  AST_POST_AVAIL: assert property ($fell(buf_available[CLS_POST_I]) |->
    $past(acc_start_w[CLS_POST_I]))
    else $error("posted availability fell without write");
  AST_TXPLL: assert property (mode_ff != txbuf_pkg::MODE_REF_TX |=>
    !tx_pll_reset_out)
    else $error("tx pll reset outside ref/tx mode");
  AST_LOCK: assert property (sy[1] |=> !rx_quarter_clock_locked)
    else $error("lock held during rx pll reset");
  AST_SEND_STABLE: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data) && $stable(tx_class))
    else $error("link word changed before taken");
  COV_BLOCKED: cover property (st_ff == txbuf_pkg::S_FETCH && fetch_blk);
  COV_REJECT: cover property (|write_reject);
  COV_INJ: cover property (inj_st_ff == txbuf_pkg::I_WRITE);
endmodule // tx_packet_buffer_ordering

// File: hw/txbuf_pkg.sv
package txbuf_pkg;
  localparam int NCLS     = 3;
  localparam int CLS_POST = 0;
  localparam int CLS_NP   = 1;
  localparam int CLS_RESP = 2;
  localparam int ADDR_W   = 5;
  localparam int PTR_W    = 6;
  localparam int BAR_W    = 8;
  localparam int WORD_W   = 78;
  // stored word: {barrier, hold, sop, eop, mty, data}
  localparam int F_MTY    = 64;
  localparam int F_EOP    = 67;
  localparam int F_SOP    = 68;
  localparam int F_HOLD   = 69;
  localparam int F_BAR    = 70;
  localparam int PPW_BIT  = 15;
  localparam logic [6:0] DEPTH_WORDS = 7'h20;
  localparam logic [6:0] PKT_WORDS   = 7'h09;
  localparam logic [3:0] LEN_MAX     = 4'h9;
  localparam logic [3:0] LEN_ONE     = 4'h1;
  localparam logic [2:0] MTY_ODD     = 3'b100;
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_INJ       = 8'h04;
  localparam logic [7:0] A_STAT      = 8'h08;
  localparam logic [1:0] MODE_SEP        = 2'h0;
  localparam logic [1:0] MODE_REF_TX     = 2'h1;
  localparam logic [1:0] MODE_RX_TX_REF  = 2'h2;
  typedef enum logic [2:0] {
    S_IDLE  = 3'b001,
    S_FETCH = 3'b010,
    S_SEND  = 3'b100
  } sched_st_t;
  typedef enum logic [2:0] {
    I_IDLE  = 3'b001,
    I_BLOCK = 3'b010,
    I_WRITE = 3'b100
  } inj_st_t;
endpackage

// File: test/tx_packet_buffer_ordering_test.sv
`timescale 1ns/1ps
module tx_packet_buffer_ordering_test;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, tx_valid, tx_sop, tx_ready = 0;
  logic lock = 0, rx_rst = 0, tx_rst = 0, qclk, locked, rx_ro, tx_ro;
  logic refc = 0, wrm = 0, cld = 0, wro, cro, tx_eop;
  logic [2:0] tx_mty;
  logic [2:0] en, sop, eop, avail, rej;
  logic [2:0][63:0] dat;
  logic [2:0][2:0] mty;
  logic [63:0] tx_data;
  logic [1:0] tx_class;
  logic [9:0] seen_q[$];
  int mismatches = 0, compares = 0;
  always #25 pclk = ~pclk;
  // reference clock runs slower than pclk and changes off its rising edge
  always #100 refc = ~refc;
  user_writer u (.pclk(pclk), .en(en), .dat(dat), .sop(sop), .eop(eop),
                 .mty(mty));
  tx_packet_buffer_ordering i_dut (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .write_enable_in(en[1:0]), .response_buf_write_enable(en[2]),
    .wr_data(dat), .wr_sop(sop), .wr_eop(eop), .wr_mty(mty),
    .buf_available(avail), .write_reject(rej), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .tx_data(tx_data), .tx_sop(tx_sop),
    .tx_eop(tx_eop), .tx_mty(tx_mty), .tx_class(tx_class),
    .rx_pll_lock(lock),
    .rx_pll_async_reset(rx_rst), .tx_pll_async_reset(tx_rst),
    .reference_clock_in(refc), .warm_reset_req(wrm),
    .cold_reset_req(cld), .rx_quarter_rate_clock(qclk),
    .rx_quarter_clock_locked(locked), .reference_clock_in_warm_reset_out(wro),
    .reference_clock_in_cold_reset_out(cro), .rx_pll_reset_out(rx_ro),
    .tx_pll_reset_out(tx_ro));
  // link stalls every other cycle so words must wait on tx_ready
  always @(posedge pclk) begin
    tx_ready <= !tx_ready;
    if (tx_valid && tx_ready && tx_sop) begin
      seen_q.push_back({tx_class, tx_data[7:0]});
    end
    if (tx_valid && tx_ready && tx_eop) begin
      check("link mty end", 32'(tx_mty), 32'h0000_0004);
    end else if (tx_valid && tx_ready) begin
      check("link mty mid", 32'(tx_mty), 32'h0000_0000);
    end
  end
  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_up(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      tally_and_finish();
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    give_up(n, 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic expect_pkt(input logic [1:0] c, input logic [7:0] tag);
    int n;
    n = 0;
    while (seen_q.size() == 0 && n < 400) begin
      @(negedge pclk);
      n++;
    end
    give_up(n, 400);
    check("link packet", 32'(seen_q.pop_front()), 32'({c, tag}));
  endtask
  // reject latency is not fixed, so watch a span of cycles
  task automatic expect_reject(input int c);
    logic hit;
    hit = 0;
    repeat (30) begin
      @(negedge pclk);
      hit = hit | (rej[c] === 1'b1);
    end
    check("write reject", 32'(hit), 32'h0000_0001);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("avail", 32'(avail), 32'h0000_0007);
    apb(1'b0, 8'h0c, 32'h0000_0000);
    check("unmapped", 32'(err), 32'h0000_0001);
    u.send(0, 2, 1'b1, 8'h11, 1'b0);
    u.send(0, 1, 1'b1, 8'h12, 1'b0);
    expect_pkt(2'h0, 8'h11);
    expect_pkt(2'h0, 8'h12);
    for (int c = 1; c < 3; c++) begin
      fork
        u.send(0, 9, 1'b0, 8'h21, 1'b0);
        begin
          @(posedge pclk);
          u.send(c, 1, 1'b0, 8'h22, 1'b0);
        end
      join
      expect_pkt(2'h0, 8'h21);
      expect_pkt(2'(c), 8'h22);
    end
    fork
      u.send(1, 2, 1'b1, 8'h31, 1'b1);
      expect_reject(1);
    join
    fork
      u.send(0, 10, 1'b1, 8'h32, 1'b0);
      expect_reject(0);
    join
    u.send(0, 1, 1'b1, 8'h33, 1'b0);
    expect_pkt(2'h0, 8'h33);
    apb(1'b1, 8'h04, 32'h0000_8055);
    for (int n = 0; avail[2] !== 1'b0; n++) begin
      give_up(n, 20);
      @(negedge pclk);
    end
    check("avail post np", 32'(avail[1:0]), 32'h0000_0003);
    fork
      u.send(2, 1, 1'b1, 8'h56, 1'b0);
      expect_reject(2);
    join
    expect_pkt(2'h2, 8'h55);
    apb(1'b1, 8'h00, 32'h0000_0001);
    lock <= 1'b1;
    rx_rst <= 1'b1;
    tx_rst <= 1'b1;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    check("lock in rx reset", 32'(locked), 32'h0000_0000);
    check("rx pll reset", 32'(rx_ro), 32'h0000_0001);
    check("tx pll reset", 32'(tx_ro), 32'h0000_0001);
    apb(1'b1, 8'h00, 32'h0000_0000);
    rx_rst <= 1'b0;
    repeat (6) @(posedge pclk);
    @(negedge pclk);
    check("tx pll reset off", 32'(tx_ro), 32'h0000_0000);
    check("lock", 32'(locked), 32'h0000_0001);
    check("warm reset idle", 32'(wro), 32'h0000_0000);
    wrm <= 1'b1;
    repeat (20) @(posedge pclk);
    @(negedge pclk);
    check("warm reset", 32'(wro), 32'h0000_0001);
    check("cold reset", 32'(cro), 32'h0000_0000);
    rd = 32'(qclk);
    repeat (2) @(negedge pclk);
    check("quarter clock", 32'(qclk), ~rd & 32'h0000_0001);
    repeat (2) @(negedge pclk);
    check("quarter clock", 32'(qclk), rd);
    tally_and_finish();
  end
endmodule // tx_packet_buffer_ordering_test

// File: test/user_writer.sv
`timescale 1ns/1ps
module user_writer (
  input  wire logic             pclk,
  output logic      [2:0]       en,
  output logic      [2:0][63:0] dat,
  output logic      [2:0]       sop,
  output logic      [2:0]       eop,
  output logic      [2:0][2:0]  mty
);
  initial begin
    en = '0;
    dat = '0;
    sop = '0;
    eop = '0;
    mty = '0;
  end
  // nosop builds a bad first word on purpose, for the missing-sop refusal test
  task automatic send(input int c, input int len, input logic ppw,
                      input logic [7:0] tag, input logic nosop);
    for (int i = 0; i < len; i++) begin
      @(posedge pclk);
      if (i == 1) begin
        en[c] <= 1'b0;
        sop[c] <= 1'b1;
        eop[c] <= 1'b1;
        dat[c] <= ~dat[c];
        @(posedge pclk);
      end
      en[c] <= 1'b1;
      sop[c] <= (i == 0) && !nosop;
      eop[c] <= (i == len - 1);
      mty[c] <= (i == len - 1) ? 3'h4 : 3'h0;
      dat[c] <= {48'h0000_0000_0000, ppw, 7'h00, tag};
    end
    @(posedge pclk);
    en[c] <= 1'b0;
    dat[c] <= ~dat[c];
  endtask
endmodule // user_writer
